/* sdd_pkg.sv */
// Constants for the supply drop detector register bank
package sdd_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_MODE_CTRL = 4'h0;
    localparam logic [3:0] OFS_LEVEL_CTRL = 4'h1;
    localparam logic [3:0] OFS_MON_OFFSET = 4'h8;
    localparam logic [3:0] OFS_MON_MONITOR_INTERRUPT_CONTROL = 4'h9;
    localparam logic [3:0] OFS_MON_FLAGS = 4'ha;
    localparam logic [3:0] OFS_MON_STATUS = 4'hb;
    localparam logic [3:0] OFS_UNLOCK = 4'hc;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int POS_RATE = 4;
    localparam int POS_RUN_LO = 2;
    localparam int POS_EDGE_LO = 1;
    localparam int POS_IE = 0;
    localparam int POS_IF = 0;
    // ------------------------------------------------------------
    // Mode codes, edge codes, zero value and unlock key
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_CONT = 2'h1;
    localparam logic [1:0] MODE_SAMPLED = 2'h2;
    localparam logic [1:0] MODE_WAKE_HOLD = 2'h3;
    localparam logic [1:0] EDGE_BELOW = 2'h0;
    localparam logic [1:0] EDGE_ABOVE = 2'h1;
    localparam logic [1:0] EDGE_CROSS = 2'h2;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] UNLOCK_KEY = 8'hd8;
    localparam int UNLOCK_WINDOW = 4;
    // ------------------------------------------------------------
    // Timing and power states
    // ------------------------------------------------------------
    localparam int CLK_HZ = 125_000_000;
    localparam int RATE_FAST_HZ = 1000;
    localparam int RATE_SLOW_HZ = 125;
    localparam int TICK_FAST = CLK_HZ / RATE_FAST_HZ;
    localparam int TICK_SLOW = CLK_HZ / RATE_SLOW_HZ;
    localparam int WAKE_HOLD_CYC = 16;
    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_SLEEP = 3'b010,
        ST_HOLD = 3'b100
    } sdd_state_e;
endpackage

/* sdd_tick_if.sv */
// Sample tick request and pulse between the bank and its divider
`timescale 1ns/10ps
interface sdd_tick_if;
    logic slow;
    logic tick;
    modport ctrl (output slow, input tick);
    modport gen (input slow, output tick);
endinterface

/* sdd_tick_gen.sv */
// Sample-rate divider giving a one-cycle enable pulse
`timescale 1ns/10ps
module sdd_tick_gen
    import sdd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic run,
    sdd_tick_if.gen tif
);
    logic [23:0] cnt_ff;
    logic [23:0] nxt_cnt;
    logic [23:0] lim;
    logic tick_ff;
    logic nxt_tick;

    always_comb begin
        lim = tif.slow ? 24'(TICK_SLOW - 1) : 24'(TICK_FAST - 1);
        nxt_cnt = cnt_ff + 24'h0001;
        nxt_tick = 1'b0;
        if (!run) begin
            nxt_cnt = 24'h0000;
        end else if (cnt_ff >= lim) begin
            nxt_cnt = 24'h0000;
            nxt_tick = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_ff <= 24'h0000;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tif.tick = tick_ff;
endmodule

/* sdd_regs.sv */
// Register bank of the supply drop detector and level monitor
`timescale 1ns/10ps
// Notes on behaviour
// RULE1: rate bit picks 1 kHz or 125 Hz
// RULE2: rate bit fuse-loaded, read-only, unprotected
// RULE3: run-mode field sets active/idle behaviour
// RULE4: wake-hold mode stalls CPU until detector runs
// RULE5: run-mode fuse-loaded, writes ignored
// RULE6: sleep-mode field sets standby behaviour
// RULE7: sleep-mode fuse-loaded, then software writable
// RULE8: threshold fuse-loaded, upper bits read zero
// RULE9: threshold code drives trip level output
// RULE10: monitor offset code, resets to zero
// RULE11: edge field selects falling, rising, either
// RULE12: enable bit gates interrupt, resets zero
// RULE13: flag set on selected crossing
// RULE14: flag frozen while detector disabled; the code still lets a write of one clear it
// RULE15: status reads one when supply below
// RULE16: software ignores status while disabled
// RULE17: sleep-mode write needs recent unlock key
// RULE18: request while enable and flag set
// RULE19: monitor follows detector mode
// RULE20: sleep uses sleep field, wake uses run
// RULE21: write one clears flag, set wins
// RULE22: reserved writes ignored, reads zero
module sdd_regs
    import sdd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic [7:0] detector_config_fuse,
    input wire logic [2:0] fuse_trip_level,
    input wire logic sleep_req,
    input wire logic mon_below,
    input wire logic det_ready,
    output logic det_enable,
    output logic det_sample_tick,
    output logic [2:0] trip_threshold_code,
    output logic [1:0] monitor_offset_code,
    output logic mon_active,
    output logic cpu_hold,
    output logic mon_irq
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic sample_rate_sel_ff, nxt_rate;
    logic [1:0] run_mode_ff, nxt_run_mode;
    logic [1:0] sleep_mode_ff, nxt_sleep_mode;
    logic [2:0] level_ff, nxt_level;
    logic [1:0] offset_ff, nxt_offset;
    logic [1:0] edge_ff, nxt_edge;
    logic ie_ff, nxt_ie;
    logic flag_ff, nxt_flag;
    logic below_ff, nxt_below;
    logic [2:0] unlock_ff, nxt_unlock;
    logic [7:0] rdata_ff, nxt_rdata;
    logic loaded_ff;
    sdd_state_e st_ff, nxt_st;
    logic [1:0] eff_mode;
    logic trigger;
    logic sample_now;
    logic fall_seen;
    logic rise_seen;
    sdd_tick_if tif ();

    // Checks below all run on this clock and rest during reset
    default clocking chk_cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sdd_tick_gen u_tick (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .run(eff_mode == MODE_SAMPLED),
        .tif(tif)
    );

    // ------------------------------------------------------------
    // Power state: sleep field in sleep, run field awake
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            ST_RUN: begin
                if (sleep_req) begin
                    nxt_st = ST_SLEEP; // RULE20
                end
            end
            ST_SLEEP: begin
                if (!sleep_req) begin
                    nxt_st = (run_mode_ff == MODE_WAKE_HOLD) ? ST_HOLD
                                                            : ST_RUN;
                end
            end
            ST_HOLD: begin
                if (det_ready) begin
                    nxt_st = ST_RUN; // RULE4
                end
            end
            default: begin
                nxt_st = ST_RUN;
            end
        endcase
    end

    always_comb begin
        if (st_ff == ST_SLEEP) begin
            eff_mode = sleep_mode_ff; // RULE20
        end else begin
            eff_mode = run_mode_ff; // RULE3
        end
        if (eff_mode == MODE_WAKE_HOLD && st_ff == ST_SLEEP) begin
            eff_mode = MODE_OFF; // RULE6
        end
    end

    assign tif.slow = sample_rate_sel_ff; // RULE1
    assign det_enable = loaded_ff && (eff_mode != MODE_OFF); // RULE19
    assign det_sample_tick = tif.tick;
    assign mon_active = det_enable; // RULE19
    assign cpu_hold = (st_ff == ST_HOLD); // RULE4
    assign trip_threshold_code = level_ff; // RULE9
    assign monitor_offset_code = offset_ff; // RULE10
    assign mon_irq = ie_ff && flag_ff; // RULE18
    assign rdata = rdata_ff;

    // ------------------------------------------------------------
    // Monitor sampling and crossing detection
    // ------------------------------------------------------------
    always_comb begin
        sample_now = det_enable &&
                     ((eff_mode != MODE_SAMPLED) || tif.tick); // RULE19
        nxt_below = sample_now ? mon_below : below_ff; // RULE15
        fall_seen = sample_now && mon_below && !below_ff;
        rise_seen = sample_now && !mon_below && below_ff;
        case (edge_ff)
            EDGE_BELOW: trigger = fall_seen; // RULE11
            EDGE_ABOVE: trigger = rise_seen;
            EDGE_CROSS: trigger = fall_seen || rise_seen;
            default: trigger = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_comb begin
        nxt_rate = sample_rate_sel_ff;
        nxt_run_mode = run_mode_ff;
        nxt_sleep_mode = sleep_mode_ff;
        nxt_level = level_ff;
        nxt_offset = offset_ff;
        nxt_edge = edge_ff;
        nxt_ie = ie_ff;
        nxt_flag = flag_ff;
        nxt_unlock = (unlock_ff != 3'h0) ? unlock_ff - 3'h1 : 3'h0;
        if (!loaded_ff) begin
            nxt_rate = detector_config_fuse[POS_RATE]; // RULE2
            nxt_run_mode = detector_config_fuse[POS_RUN_LO +: 2]; // RULE5
            nxt_sleep_mode = detector_config_fuse[1:0]; // RULE7
            nxt_level = fuse_trip_level; // RULE8
        end
        if (wr) begin
            case (addr)
                OFS_MODE_CTRL: begin
                    if (unlock_ff != 3'h0) begin
                        nxt_sleep_mode = wdata[1:0]; // RULE17
                    end
                end
                OFS_MON_OFFSET: nxt_offset = wdata[1:0]; // RULE10
                OFS_MON_MONITOR_INTERRUPT_CONTROL: begin
                    nxt_edge = wdata[POS_EDGE_LO +: 2]; // RULE11
                    nxt_ie = wdata[POS_IE]; // RULE12
                end
                OFS_MON_FLAGS: begin
                    if (wdata[POS_IF]) begin
                        nxt_flag = 1'b0; // RULE21
                    end
                end
                OFS_UNLOCK: begin
                    if (wdata == UNLOCK_KEY) begin
                        nxt_unlock = 3'(UNLOCK_WINDOW); // RULE17
                    end
                end
                default: ; // RULE22
            endcase
        end
        if (trigger) begin
            nxt_flag = 1'b1; // RULE13 RULE21
        end
        if (!det_enable) begin
            nxt_flag = flag_ff; // RULE14
            if (wr && addr == OFS_MON_FLAGS && wdata[POS_IF]) begin
                nxt_flag = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Read path, data in the cycle after the strobe
    // ------------------------------------------------------------
    always_comb begin
        nxt_rdata = RST_ZERO;
        if (rd) begin
            case (addr)
                OFS_MODE_CTRL: nxt_rdata = {3'h0, sample_rate_sel_ff,
                                            run_mode_ff, sleep_mode_ff};
                OFS_LEVEL_CTRL: nxt_rdata = {5'h00, level_ff}; // RULE8
                OFS_MON_OFFSET: nxt_rdata = {6'h00, offset_ff};
                OFS_MON_MONITOR_INTERRUPT_CONTROL: nxt_rdata = {5'h00, edge_ff, ie_ff};
                OFS_MON_FLAGS: nxt_rdata = {7'h00, flag_ff};
                OFS_MON_STATUS: nxt_rdata = {7'h00, below_ff}; // RULE15
                default: nxt_rdata = RST_ZERO; // RULE22
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sample_rate_sel_ff <= 1'b0;
            run_mode_ff <= MODE_OFF;
            sleep_mode_ff <= MODE_OFF;
            level_ff <= 3'h0;
            offset_ff <= 2'h0;
            edge_ff <= EDGE_BELOW;
            ie_ff <= 1'b0;
            flag_ff <= 1'b0;
            below_ff <= 1'b0;
            unlock_ff <= 3'h0;
            rdata_ff <= RST_ZERO;
            loaded_ff <= 1'b0;
            st_ff <= ST_RUN;
        end else begin
            sample_rate_sel_ff <= nxt_rate;
            run_mode_ff <= nxt_run_mode;
            sleep_mode_ff <= nxt_sleep_mode;
            level_ff <= nxt_level;
            offset_ff <= nxt_offset;
            edge_ff <= nxt_edge;
            ie_ff <= nxt_ie;
            flag_ff <= nxt_flag;
            below_ff <= nxt_below;
            unlock_ff <= nxt_unlock;
            rdata_ff <= nxt_rdata;
            loaded_ff <= 1'b1;
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic key_wr;
    logic clr_wr;
    logic ctl_wr;

    assign key_wr = wr && addr == OFS_UNLOCK && wdata == UNLOCK_KEY;
    assign clr_wr = wr && addr == OFS_MON_FLAGS && wdata[POS_IF];
    assign ctl_wr = wr && addr == OFS_MON_MONITOR_INTERRUPT_CONTROL;

    sequence unlock_seq;
        wr && addr == OFS_UNLOCK && wdata == UNLOCK_KEY;
    endsequence

    sequence locked_sleep_write;
        wr && addr == OFS_MODE_CTRL && unlock_ff == 3'h0;
    endsequence

    // Key written, then four cycles with no fresh key
    sequence window_lapsed;
        key_wr ##1 (!key_wr) [*4];
    endsequence

    // Request up with no write that may take it down
    sequence irq_standing;
        mon_irq && !clr_wr && !ctl_wr;
    endsequence

    // Wake from sleep with the run field asking for the hold
    sequence wake_into_hold;
        st_ff == ST_SLEEP && !sleep_req && run_mode_ff == MODE_WAKE_HOLD;
    endsequence

    irq_level_a: assert property (irq_standing |=> mon_irq) // RULE18
        else $error("irq dropped with flag and enable held");

    irq_masked_a: assert property ((!ie_ff && !ctl_wr) |=> !mon_irq) // RULE12
        else $error("irq raised while disabled");

    flag_set_a: assert property (trigger |=> flag_ff) // RULE13
        else $error("flag not set after trigger");

    set_wins_a: assert property ((trigger && clr_wr) |=> flag_ff) // RULE21
        else $error("clear beat set");

    flag_clear_a: assert property (clr_wr && !trigger |=> !flag_ff) // RULE21
        else $error("flag not cleared");

    frozen_flag_a: assert property ( // RULE14
        (!det_enable && !(wr && addr == OFS_MON_FLAGS))
        |=> flag_ff == $past(flag_ff))
        else $error("flag moved while disabled");

    locked_write_a: assert property ( // RULE17
        (loaded_ff and locked_sleep_write) |=> $stable(sleep_mode_ff))
        else $error("sleep field changed without unlock");

    unlock_open_a: assert property ( // RULE17
        unlock_seq ##[1:4] (wr && addr == OFS_MODE_CTRL)
        |=> sleep_mode_ff == $past(wdata[1:0]))
        else $error("unlocked sleep write lost");

    window_open_a: assert property ( // RULE17
        key_wr |=> unlock_ff == 3'(UNLOCK_WINDOW))
        else $error("unlock window not opened");

    window_shut_a: assert property (window_lapsed |=> unlock_ff == 3'h0) // RULE17
        else $error("unlock window left open");

    run_fixed_a: assert property ( // RULE5
        loaded_ff |=> $stable(run_mode_ff) && $stable(level_ff))
        else $error("fuse field changed");

    level_read_a: assert property ( // RULE8
        (rd && addr == OFS_LEVEL_CTRL) |=> rdata[7:3] == 5'h00)
        else $error("upper threshold bits nonzero");

    hold_wake_a: assert property ( // RULE4
        (st_ff == ST_HOLD && det_ready) |=> !cpu_hold)
        else $error("hold not released");

    wake_hold_a: assert property (wake_into_hold |=> cpu_hold) // RULE4
        else $error("hold missing after wake");

    sleep_enter_a: assert property ( // RULE20
        (st_ff == ST_RUN && sleep_req) |=> st_ff == ST_SLEEP)
        else $error("sleep setting not taken");

    wake_run_a: assert property ( // RULE20
        (st_ff == ST_SLEEP && !sleep_req && run_mode_ff != MODE_WAKE_HOLD)
        |=> st_ff == ST_RUN)
        else $error("run setting not taken on wake");

    sample_gate_a: assert property ( // RULE19
        (eff_mode == MODE_SAMPLED && !tif.tick) |=> $stable(below_ff))
        else $error("status moved between samples");

    off_status_a: assert property (!det_enable |=> $stable(below_ff)) // RULE14
        else $error("status moved while disabled");
endmodule

/* sdd_regs_bench.sv */
// Self-checking bench for the supply drop detector register bank
`timescale 1ns/10ps
module sdd_regs_bench
    import sdd_pkg::*;
;
    // -------------------------------------------------------------
    // Signals
    // -------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] fuse = 8'h00;
    logic [2:0] trip = 3'h0;
    logic sleep_req = 1'b0;
    logic mon_below = 1'b0;
    logic det_ready = 1'b0;
    logic [7:0] rdata;
    logic det_enable;
    logic det_tick;
    logic [2:0] trip_out;
    logic [1:0] ofs_out;
    logic mon_active;
    logic cpu_hold;
    logic mon_irq;
    logic [31:0] rng = 32'h0000_a90b;
    int errors = 0;
    int checks_done = 0;

    sdd_regs dut (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .detector_config_fuse(fuse), .fuse_trip_level(trip),
        .sleep_req(sleep_req), .mon_below(mon_below),
        .det_ready(det_ready), .det_enable(det_enable),
        .det_sample_tick(det_tick), .trip_threshold_code(trip_out),
        .monitor_offset_code(ofs_out), .mon_active(mon_active),
        .cpu_hold(cpu_hold), .mon_irq(mon_irq));

    always #4 ref_clk = ~ref_clk;

    // -------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Flag expected after the monitor moves to the given side
    function automatic logic [7:0] exp_flag(input logic [1:0] e,
                                            input logic below);
        logic hit;
        hit = (e == EDGE_CROSS) || (e == EDGE_BELOW && below) ||
              (e == EDGE_ABOVE && !below);
        return {7'h00, hit};
    endfunction

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] seen);
        checks_done++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, seen);
            errors++;
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [3:0] a,
                          input logic [7:0] exp);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        chk(what, exp, rdata);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic drive_below(input logic v);
        @(posedge ref_clk);
        mon_below <= v;
        wait_cyc(4);
    endtask

    task automatic set_sleep(input logic [7:0] d);
        reg_wr(OFS_UNLOCK, UNLOCK_KEY);
        reg_wr(OFS_MODE_CTRL, d);
    endtask

    task automatic do_reset(input logic [7:0] f);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        fuse <= f;
        trip <= rng[2:0];
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        test_done;
    end

    // -------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------
    initial begin
        rng = lfsr_next(rng);
        do_reset({3'b101, rng[4], MODE_CONT, MODE_CONT});
        rd_chk("mode", OFS_MODE_CTRL, {3'b000, fuse[4:0]});
        rd_chk("level", OFS_LEVEL_CTRL, {5'h00, trip});
        chk("trip_out", {5'h00, trip}, {5'h00, trip_out});
        for (int a = 8; a < 12; a++) begin
            rd_chk("rst_val", 4'(a), RST_ZERO);
        end
        // Writes to read-only and reserved places
        for (int a = 0; a < 8; a++) begin
            rng = lfsr_next(rng);
            reg_wr(4'(a), rng[7:0]);
        end
        reg_wr(OFS_MON_STATUS, 8'hff);
        rd_chk("mode_lock", OFS_MODE_CTRL, {3'b000, fuse[4:0]});
        rd_chk("level_ro", OFS_LEVEL_CTRL, {5'h00, trip});
        rd_chk("status_ro", OFS_MON_STATUS, RST_ZERO);
        for (int a = 2; a < 8; a++) begin
            rd_chk("reserved", 4'(a), RST_ZERO);
        end
        // Protected sleep field
        set_sleep(8'hfe);
        rd_chk("sleep_wr", OFS_MODE_CTRL,
               {3'b000, fuse[4:2], MODE_SAMPLED});
        reg_wr(OFS_UNLOCK, UNLOCK_KEY);
        wait_cyc(8);
        reg_wr(OFS_MODE_CTRL, 8'h00);
        rd_chk("sleep_late", OFS_MODE_CTRL,
               {3'b000, fuse[4:2], MODE_SAMPLED});
        for (int c = 0; c < 3; c++) begin
            rng = lfsr_next(rng);
            reg_wr(OFS_MON_OFFSET, {rng[7:2], 2'(c)});
            rd_chk("offset", OFS_MON_OFFSET, {6'h00, 2'(c)});
            chk("offset_out", {6'h00, 2'(c)}, {6'h00, ofs_out});
        end
        // Each trigger edge, both directions
        for (int e = 0; e < 3; e++) begin
            rng = lfsr_next(rng);
            reg_wr(OFS_MON_MONITOR_INTERRUPT_CONTROL, {rng[7:3], 2'(e), 1'b1});
            rd_chk("monitor_interrupt_control", OFS_MON_MONITOR_INTERRUPT_CONTROL,
                   {5'h00, 2'(e), 1'b1});
            reg_wr(OFS_MON_FLAGS, 8'h01);
            rd_chk("flag_clr", OFS_MON_FLAGS, RST_ZERO);
            drive_below(1'b1);
            rd_chk("status_lo", OFS_MON_STATUS, 8'h01);
            rd_chk("flag_fall", OFS_MON_FLAGS,
                   exp_flag(2'(e), 1'b1));
            chk("irq_fall", exp_flag(2'(e), 1'b1),
                {7'h00, mon_irq});
            reg_wr(OFS_MON_FLAGS, 8'h01);
            drive_below(1'b0);
            rd_chk("status_hi", OFS_MON_STATUS, RST_ZERO);
            rd_chk("flag_rise", OFS_MON_FLAGS,
                   exp_flag(2'(e), 1'b0));
        end
        // Flag is set; write zero, mask, clear
        reg_wr(OFS_MON_FLAGS, 8'h00);
        rd_chk("flag_w0", OFS_MON_FLAGS, 8'h01);
        reg_wr(OFS_MON_MONITOR_INTERRUPT_CONTROL, {5'h00, EDGE_CROSS, 1'b0});
        wait_cyc(1);
        chk("irq_mask", 8'h00, {7'h00, mon_irq});
        rd_chk("flag_kept", OFS_MON_FLAGS, 8'h01);
        reg_wr(OFS_MON_MONITOR_INTERRUPT_CONTROL, {5'h00, EDGE_CROSS, 1'b1});
        wait_cyc(1);
        chk("irq_on", 8'h01, {7'h00, mon_irq});
        reg_wr(OFS_MON_FLAGS, 8'h01);
        wait_cyc(1);
        chk("irq_clr", 8'h00, {7'h00, mon_irq});
        // Sleep with the sleep field off
        set_sleep(8'h00);
        wait_cyc(1);
        chk("run_on", 8'h01, {7'h00, det_enable});
        @(posedge ref_clk);
        sleep_req <= 1'b1;
        wait_cyc(3);
        chk("sleep_off", 8'h00, {7'h00, det_enable});
        chk("mon_off", 8'h00, {7'h00, mon_active});
        drive_below(1'b1);
        rd_chk("flag_frz", OFS_MON_FLAGS, RST_ZERO);
        drive_below(1'b0);
        @(posedge ref_clk);
        sleep_req <= 1'b0;
        wait_cyc(3);
        chk("wake_on", 8'h01, {7'h00, det_enable});
        // Clear and crossing in the same cycle: the set wins
        @(posedge ref_clk);
        mon_below <= 1'b1;
        addr <= OFS_MON_FLAGS;
        wdata <= 8'h01;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
        rd_chk("set_wins", OFS_MON_FLAGS, 8'h01);
        // Sampled sleep: nothing is sampled before the first tick
        set_sleep(8'h02);
        reg_wr(OFS_MON_FLAGS, 8'h01);
        @(posedge ref_clk);
        sleep_req <= 1'b1;
        drive_below(1'b0);
        chk("smp_on", 8'h01, {7'h00, det_enable});
        chk("tick_idle", 8'h00, {7'h00, det_tick});
        rd_chk("smp_stat", OFS_MON_STATUS, 8'h01);
        rd_chk("smp_flag", OFS_MON_FLAGS, RST_ZERO);
        @(posedge ref_clk);
        sleep_req <= 1'b0;
        // Wake hold mode
        rng = lfsr_next(rng);
        do_reset({3'b000, rng[4], MODE_WAKE_HOLD, MODE_OFF});
        rd_chk("mode_wh", OFS_MODE_CTRL, {3'b000, fuse[4:0]});
        chk("no_hold", 8'h00, {7'h00, cpu_hold});
        @(posedge ref_clk);
        sleep_req <= 1'b1;
        wait_cyc(3);
        @(posedge ref_clk);
        sleep_req <= 1'b0;
        wait_cyc(2);
        chk("hold", 8'h01, {7'h00, cpu_hold});
        @(posedge ref_clk);
        det_ready <= 1'b1;
        wait_cyc(4);
        chk("release", 8'h00, {7'h00, cpu_hold});
        test_done;
    end
endmodule
